// file: hdl/stec_csr.sv
// register bank holding sdram timing parameters and ecc control and status
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module stec_csr import stec_pkg::*; #(
	parameter bit ECC_BUILT = 1'b1
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire stec_event_type EVT,
	output stec_timing_type TIMING,
	output stec_ecc_cfg_type ECC_CFG,
	output logic IRQ
);

	stec_state_type s_q;
	stec_state_type s_d;
	logic clr;
	logic any_err;

	// every check in this module runs on the one clock and is muted during reset
	default clocking stec_cb @(posedge CLOCK);
	endclocking
	default disable iff (SRST);

	//////////////////////////////////////////////////////////////////////////////
	// next-state logic: writes, clear, error events, read data
	always_comb begin
		s_d = s_q;
		clr = 1'b0;
		any_err = EVT.single_fault | EVT.double_fault;
		// read data stands for one cycle only
		s_d.rdata = '0;
		if (WR) begin
			unique case (ADDR)
				stec_byte_addr(IDX_ROW): begin
					s_d.timing.row = stec_row_type'(WDATA);
				end
				stec_byte_addr(IDX_TURN): begin
					s_d.timing.turn = stec_turn_type'(WDATA);
					s_d.timing.turn.rsvd = '0;
				end
				stec_byte_addr(IDX_REFRESH): begin
					s_d.timing.refresh = stec_refresh_type'(WDATA);
					s_d.timing.refresh.rsvd = '0;
				end
				stec_byte_addr(IDX_LAT): begin
					s_d.timing.lat = stec_lat_type'(WDATA);
					s_d.timing.lat.rsvd = '0;
				end
				stec_byte_addr(IDX_CTRL): begin
					s_d.ctrl = stec_ctrl_type'(WDATA);
					s_d.ctrl.rsvd = '0;
					clr = WDATA[7];
					s_d.ctrl.clear = 1'b0;
				end
				default: begin
					// read-only and unmapped addresses ignore writes
				end
			endcase
		end
		// clear first, so an event in the same cycle still lands
		if (clr) begin
			s_d.status = '0;
			s_d.err_addr = '0;
		end
		if (EVT.single_fault) begin
			s_d.status.single_fault_flag = 1'b1;
			s_d.status.single_fault_tally = stec_sat_inc(s_d.status.single_fault_tally);
		end
		if (EVT.double_fault) begin
			s_d.status.double_fault_flag = 1'b1;
			s_d.status.double_fault_tally = stec_sat_inc(s_d.status.double_fault_tally);
		end
		if (EVT.lost_fix) begin
			s_d.status.lost_fix_flag = 1'b1;
			s_d.status.lost_fix_tally = stec_sat_inc(s_d.status.lost_fix_tally);
		end
		if (any_err) begin
			s_d.err_addr = EVT.addr;
		end
		// interrupt follows the new flags and control in the same edge
		s_d.irq = s_d.ctrl.irq_output_enable &
			((s_d.status.single_fault_flag & ~s_d.ctrl.single_fault_irq_mask) |
			(s_d.status.double_fault_flag & ~s_d.ctrl.double_fault_irq_mask) |
			(s_d.status.lost_fix_flag & ~s_d.ctrl.lost_fix_irq_mask));
		// the ecc enable has no effect in a build without ecc
		s_d.cfg.ecc_on = ECC_BUILT & s_d.ctrl.ecc_enable;
		s_d.cfg.scrub = ECC_BUILT & s_d.ctrl.scrub_on_single_error;
		s_d.cfg.inject_mask[0] = s_d.ctrl.inject_one_bit_fault | s_d.ctrl.inject_two_bit_fault;
		s_d.cfg.inject_mask[1] = s_d.ctrl.inject_two_bit_fault;
		// reads show the values before this cycle's update
		if (RD) begin
			unique case (ADDR)
				stec_byte_addr(IDX_ROW): s_d.rdata = s_q.timing.row;
				stec_byte_addr(IDX_TURN): s_d.rdata = s_q.timing.turn;
				stec_byte_addr(IDX_REFRESH): s_d.rdata = s_q.timing.refresh;
				stec_byte_addr(IDX_LAT): s_d.rdata = s_q.timing.lat;
				stec_byte_addr(IDX_CTRL): s_d.rdata = s_q.ctrl;
				stec_byte_addr(IDX_STAT): s_d.rdata = s_q.status;
				stec_byte_addr(IDX_EADDR): s_d.rdata = s_q.err_addr;
				default: s_d.rdata = '0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// state register; clock enable low freezes everything, but synchronous reset still loads
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			s_q.timing.row <= ROW_RST;
			s_q.timing.turn <= TURN_RST;
			s_q.timing.refresh <= REFRESH_RST;
			s_q.timing.lat <= LAT_RST;
			s_q.ctrl <= CTRL_RST;
			s_q.status <= '0;
			s_q.err_addr <= '0;
			s_q.cfg <= stec_ecc_cfg_type'({CFG_RST.ecc_on & ECC_BUILT, CFG_RST[2:0]});
			s_q.rdata <= '0;
			s_q.irq <= 1'b0;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	// outputs come straight from the state register
	assign RDATA = s_q.rdata;
	assign TIMING = s_q.timing;
	assign ECC_CFG = s_q.cfg;
	assign IRQ = s_q.irq;

	//////////////////////////////////////////////////////////////////////////////
	// checks on the register behaviour
	a_row_write_lands: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && WR && ADDR == stec_byte_addr(IDX_ROW)) |=> (TIMING.row == $past(WDATA)))
		else $error("row timing write not applied");

	a_status_read_data: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && RD && ADDR == stec_byte_addr(IDX_STAT)) |=> (RDATA == $past(s_q.status)))
		else $error("status read returned wrong data");

	a_single_flag_sets: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && EVT.single_fault) |=> s_q.status.single_fault_flag)
		else $error("single fault flag not set");

	a_flag_sticky_hold: assert property (@(posedge CLOCK) disable iff (SRST)
		(s_q.status.double_fault_flag && !(CE && clr)) |=> s_q.status.double_fault_flag)
		else $error("double fault flag dropped without clear");

	a_tally_counts_up: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && EVT.single_fault && !clr && s_q.status.single_fault_tally != TALLY_MAX)
		|=> (s_q.status.single_fault_tally == $past(s_q.status.single_fault_tally) + 8'h01))
		else $error("single fault tally did not advance");

	a_tally_saturates: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && EVT.lost_fix && !clr && s_q.status.lost_fix_tally == TALLY_MAX) |=> (s_q.status.lost_fix_tally == TALLY_MAX))
		else $error("lost fix tally wrapped");

	a_clear_empties_all: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && clr && !EVT.single_fault && !EVT.double_fault && !EVT.lost_fix)
		|=> (s_q.status == '0 && s_q.err_addr == '0 && !IRQ && !s_q.ctrl.clear))
		else $error("clear left state behind");

	a_irq_needs_enable: assert property (@(posedge CLOCK) disable iff (SRST)
		!s_q.ctrl.irq_output_enable |-> !IRQ)
		else $error("interrupt while disabled");

	a_irq_masked_single: assert property (@(posedge CLOCK) disable iff (SRST)
		(s_q.ctrl.single_fault_irq_mask && !s_q.status.double_fault_flag && !s_q.status.lost_fix_flag) |-> !IRQ)
		else $error("masked single fault raised interrupt");

	a_error_addr_kept: assert property (@(posedge CLOCK) disable iff (SRST)
		(CE && EVT.double_fault) |=> (s_q.err_addr == $past(EVT.addr)))
		else $error("error address not captured");

	a_inject_two_bits: assert property (@(posedge CLOCK) disable iff (SRST)
		s_q.ctrl.inject_two_bit_fault |-> (ECC_CFG.inject_mask == 2'h3))
		else $error("double fault injection mask wrong");

	//////////////////////////////////////////////////////////////////////////////
	// timing fields land as written and hold otherwise
	// turnaround write keeps its reserved half at zero
	a_turn_write_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_TURN))
		|=> (TIMING.turn == {16'h0000, $past(WDATA[15:0])}))
		else $error("turn timing write not applied");

	// four-activate window field
	a_window_field_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_TURN))
		|=> (TIMING.turn.four_act_window == $past(WDATA[15:8])))
		else $error("activate window field not applied");

	// refresh interval field
	a_refresh_write_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_REFRESH))
		|=> (TIMING.refresh.refresh_interval == $past(WDATA[15:0])))
		else $error("refresh interval not applied");

	// refresh cycle field, reserved byte stays zero
	a_refresh_cycle_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_REFRESH))
		|=> (TIMING.refresh.refresh_cycle == $past(WDATA[23:16]) && TIMING.refresh.rsvd == 8'h00))
		else $error("refresh cycle field not applied");

	// latency register keeps its top twelve bits at zero
	a_lat_write_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_LAT))
		|=> (TIMING.lat == {12'h000, $past(WDATA[19:0])}))
		else $error("latency write not applied");

	// spacing between activates to different banks
	a_row_spacing_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_ROW))
		|=> (TIMING.row.act_act_diff == $past(WDATA[7:4])))
		else $error("activate spacing field not applied");

	// activate-to-precharge field
	a_row_precharge_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_ROW))
		|=> (TIMING.row.act_pre == $past(WDATA[23:16])))
		else $error("activate to precharge field not applied");

	// same-bank activate-to-activate field
	a_row_cycle_lands: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_ROW))
		|=> (TIMING.row.act_act_same == $past(WDATA[31:24])))
		else $error("same bank activate field not applied");

	// the scheduler must never see timing move without a write
	a_timing_held: assert property (
		(CE && !SRST && !WR)
		|=> $stable(TIMING))
		else $error("timing changed without a write");

	//////////////////////////////////////////////////////////////////////////////
	// ecc steering and control register
	// ecc enable only reaches the datapath in a build with ecc
	a_ecc_enable_follows: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_CTRL))
		|=> (ECC_CFG.ecc_on == (ECC_BUILT && $past(WDATA[0]))))
		else $error("ecc enable not steered");

	// automatic correction follows its control bit
	a_scrub_follows: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_CTRL))
		|=> (ECC_CFG.scrub == (ECC_BUILT && $past(WDATA[1]))))
		else $error("scrub enable not steered");

	// single injection flips data bit 0 only
	a_inject_one_bit: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_CTRL) && WDATA[2] && !WDATA[3])
		|=> (ECC_CFG.inject_mask == 2'h1))
		else $error("single fault injection mask wrong");

	// no injection bits, no flipped data
	a_inject_cleared: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_CTRL) && !WDATA[2] && !WDATA[3])
		|=> (ECC_CFG.inject_mask == 2'h0))
		else $error("injection left on");

	// control reads back with the clear bit low
	a_ctrl_reads_back: assert property (
		(CE && RD && ADDR == stec_byte_addr(IDX_CTRL))
		|=> (RDATA == $past(s_q.ctrl) && !RDATA[7]))
		else $error("control read returned wrong data");

	// the clear bit never stays set
	a_clear_self_clears: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_CTRL) && WDATA[7])
		|=> !s_q.ctrl.clear)
		else $error("clear bit stayed set");

	//////////////////////////////////////////////////////////////////////////////
	// error flags, tallies and address
	// double fault sets its flag
	a_double_flag_sets: assert property (
		(CE && EVT.double_fault)
		|=> s_q.status.double_fault_flag)
		else $error("double fault flag not set");

	// dropped correction sets its flag
	a_lost_flag_sets: assert property (
		(CE && EVT.lost_fix)
		|=> s_q.status.lost_fix_flag)
		else $error("lost fix flag not set");

	// double fault tally steps by one
	a_double_tally_counts: assert property (
		(CE && EVT.double_fault && !clr && s_q.status.double_fault_tally != TALLY_MAX)
		|=> (s_q.status.double_fault_tally == $past(s_q.status.double_fault_tally) + 8'h01))
		else $error("double fault tally did not advance");

	// lost fix tally steps by one
	a_lost_tally_counts: assert property (
		(CE && EVT.lost_fix && !clr && s_q.status.lost_fix_tally != TALLY_MAX)
		|=> (s_q.status.lost_fix_tally == $past(s_q.status.lost_fix_tally) + 8'h01))
		else $error("lost fix tally did not advance");

	// single fault tally stops at its top value
	a_single_tally_saturates: assert property (
		(CE && EVT.single_fault && !clr && s_q.status.single_fault_tally == TALLY_MAX)
		|=> (s_q.status.single_fault_tally == TALLY_MAX))
		else $error("single fault tally wrapped");

	// tally moves only on an event or a clear
	a_tally_holds_idle: assert property (
		(CE && !SRST && !EVT.single_fault && !clr)
		|=> $stable(s_q.status.single_fault_tally))
		else $error("single fault tally moved without event");

	// a clear without a double fault empties that tally
	a_tally_clears: assert property (
		(CE && clr && !EVT.double_fault)
		|=> (s_q.status.double_fault_tally == 8'h00))
		else $error("double fault tally not cleared");

	// status is read only for software
	a_status_write_ignored: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_STAT) && !EVT.single_fault && !EVT.double_fault && !EVT.lost_fix)
		|=> (s_q.status == $past(s_q.status)))
		else $error("status changed by a write");

	// error address is read only for software
	a_eaddr_write_ignored: assert property (
		(CE && WR && ADDR == stec_byte_addr(IDX_EADDR) && !EVT.single_fault && !EVT.double_fault)
		|=> (s_q.err_addr == $past(s_q.err_addr)))
		else $error("error address changed by a write");

	// single faults record their address too
	a_single_addr_kept: assert property (
		(CE && EVT.single_fault)
		|=> (s_q.err_addr == $past(EVT.addr)))
		else $error("single fault address not captured");

	// a dropped correction alone leaves the address alone
	a_lost_keeps_addr: assert property (
		(CE && EVT.lost_fix && !EVT.single_fault && !EVT.double_fault && !clr)
		|=> (s_q.err_addr == $past(s_q.err_addr)))
		else $error("lost fix overwrote error address");

	// error address read returns the stored value
	a_eaddr_read_data: assert property (
		(CE && RD && ADDR == stec_byte_addr(IDX_EADDR))
		|=> (RDATA == $past(s_q.err_addr)))
		else $error("error address read returned wrong data");

	// clock enable low freezes sticky flags and all other state
	a_freeze_holds: assert property (
		(!CE && !SRST)
		|=> (s_q == $past(s_q)))
		else $error("state moved while clock enable low");

	//////////////////////////////////////////////////////////////////////////////
	// interrupt from unmasked flags
	// unmasked double fault raises the interrupt
	a_irq_from_double: assert property (
		(s_q.ctrl.irq_output_enable && s_q.status.double_fault_flag && !s_q.ctrl.double_fault_irq_mask)
		|-> IRQ)
		else $error("double fault did not raise interrupt");

	// unmasked dropped correction raises the interrupt
	a_irq_from_lost: assert property (
		(s_q.ctrl.irq_output_enable && s_q.status.lost_fix_flag && !s_q.ctrl.lost_fix_irq_mask)
		|-> IRQ)
		else $error("lost fix did not raise interrupt");

	// masked double fault stays quiet
	a_irq_masked_double: assert property (
		(s_q.ctrl.double_fault_irq_mask && !s_q.status.single_fault_flag && !s_q.status.lost_fix_flag)
		|-> !IRQ)
		else $error("masked double fault raised interrupt");

	// masked dropped correction stays quiet
	a_irq_masked_lost: assert property (
		(s_q.ctrl.lost_fix_irq_mask && !s_q.status.single_fault_flag && !s_q.status.double_fault_flag)
		|-> !IRQ)
		else $error("masked lost fix raised interrupt");

	c_single_event: cover property (@(posedge CLOCK) disable iff (SRST) CE && EVT.single_fault);
	c_clear_write: cover property (@(posedge CLOCK) disable iff (SRST) CE && clr);
	c_irq_rise: cover property (@(posedge CLOCK) disable iff (SRST) $rose(IRQ));
	c_tally_full: cover property (@(posedge CLOCK) disable iff (SRST) s_q.status.single_fault_tally == TALLY_MAX);
	c_lost_full: cover property (@(posedge CLOCK) disable iff (SRST) s_q.status.lost_fix_tally == TALLY_MAX);

endmodule : stec_csr

// file: hdl/stec_pkg.sv
// package of register layouts, reset values and indices for the sdram timing and ecc csr bank
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - activate-to-access delay in bits 3:0, precharge-to-activate in 11:8, 2 to 11.
// - activate spacing between different banks in bits 7:4, 2 to 8 cycles.
// - activate-to-precharge time in bits 23:16, 4 to 29 cycles, before precharge.
// - same-bank activate-to-activate time in bits 31:24, 8 to 40 cycles.
// - write-to-read turnaround in bits 3:0 (1 to 10), read-to-precharge in 7:4.
// - at most four activates per rolling window from bits 15:8, 6 to 32.
// - periodic refresh interval in bits 15:0, 780 to 6240 cycles.
// - refresh cycle wait after each refresh in bits 23:16, 12 to 88.
// - additive latency at bits 7:4, cas write latency at 11:8 time data.
// - control bit 0, reset one, enables check bit generation and checking if built.
// - control bit 1 schedules automatic correction on single-bit errors.
// - control bit 2 flips data bit 0 of every written word.
// - control bit 3 flips data bits 0 and 1 of every written word.
// - interrupt output driven only while control bit 4 is one; resets to one.
// - bits 5, 6, 8 mask single, double and dropped-correction interrupts.
// - writing one to control bit 7 clears interrupt, status and address; self-clears.
// - status bits 0, 1, 2 stick on single, double, dropped-correction events.
// - status bits 15:8, 23:16, 31:24 count those events since the last clear.
// - read-only register holds burst-aligned address of the most recent ecc error.
//////////////////////////////////////////////////////////////////////////////
package stec_pkg;

	// register indices; byte address is four times the index
	localparam int unsigned ADDR_W = 12;
	localparam logic [8:0] IDX_ROW = 9'h123;
	localparam logic [8:0] IDX_TURN = 9'h124;
	localparam logic [8:0] IDX_REFRESH = 9'h125;
	localparam logic [8:0] IDX_LAT = 9'h126;
	localparam logic [8:0] IDX_CTRL = 9'h130;
	localparam logic [8:0] IDX_STAT = 9'h131;
	localparam logic [8:0] IDX_EADDR = 9'h132;
	localparam logic [7:0] TALLY_MAX = 8'hFF;

	typedef struct packed {
		logic [7:0] act_act_same;
		logic [7:0] act_pre;
		logic [3:0] mode_load;
		logic [3:0] pre_act;
		logic [3:0] act_act_diff;
		logic [3:0] act_access;
	} stec_row_type;

	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0] four_act_window;
		logic [3:0] rd_pre;
		logic [3:0] wr_rd;
	} stec_turn_type;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] refresh_cycle;
		logic [15:0] refresh_interval;
	} stec_refresh_type;

	typedef struct packed {
		logic [11:0] rsvd;
		logic [3:0] burst_len;
		logic [3:0] wr_recovery;
		logic [3:0] cas_wr_lat;
		logic [3:0] additive_lat;
		logic [3:0] cas_lat;
	} stec_lat_type;

	typedef struct packed {
		logic [22:0] rsvd;
		logic lost_fix_irq_mask;
		logic clear;
		logic double_fault_irq_mask;
		logic single_fault_irq_mask;
		logic irq_output_enable;
		logic inject_two_bit_fault;
		logic inject_one_bit_fault;
		logic scrub_on_single_error;
		logic ecc_enable;
	} stec_ctrl_type;

	typedef struct packed {
		logic [7:0] lost_fix_tally;
		logic [7:0] double_fault_tally;
		logic [7:0] single_fault_tally;
		logic [4:0] rsvd;
		logic lost_fix_flag;
		logic double_fault_flag;
		logic single_fault_flag;
	} stec_status_type;

	// timing fields handed to the command scheduler
	typedef struct packed {
		stec_row_type row;
		stec_turn_type turn;
		stec_refresh_type refresh;
		stec_lat_type lat;
	} stec_timing_type;

	// one-cycle error reports from the ecc datapath, same clock
	typedef struct packed {
		logic single_fault;
		logic double_fault;
		logic lost_fix;
		logic [31:0] addr;
	} stec_event_type;

	// ecc steering handed to the datapath
	typedef struct packed {
		logic ecc_on;
		logic scrub;
		logic [1:0] inject_mask;
	} stec_ecc_cfg_type;

	typedef struct packed {
		stec_timing_type timing;
		stec_ctrl_type ctrl;
		stec_status_type status;
		logic [31:0] err_addr;
		stec_ecc_cfg_type cfg;
		logic [31:0] rdata;
		logic irq;
	} stec_state_type;

	// reset values of the timing registers sit inside the legal ranges
	localparam stec_row_type ROW_RST = stec_row_type'(32'h140F_4646);
	localparam stec_turn_type TURN_RST = stec_turn_type'(32'h0000_1444);
	localparam stec_refresh_type REFRESH_RST = stec_refresh_type'(32'h0034_0618);
	localparam stec_lat_type LAT_RST = stec_lat_type'(32'h0008_6506);
	localparam stec_ctrl_type CTRL_RST = stec_ctrl_type'(32'h0000_0011);
	localparam stec_ecc_cfg_type CFG_RST = stec_ecc_cfg_type'(4'h8);

	function automatic logic [ADDR_W-1:0] stec_byte_addr(input logic [8:0] idx);
		return {1'b0, idx, 2'b00};
	endfunction : stec_byte_addr

	// counters hold at their top value instead of wrapping
	function automatic logic [7:0] stec_sat_inc(input logic [7:0] v);
		return (v == TALLY_MAX) ? v : v + 8'h01;
	endfunction : stec_sat_inc

endpackage : stec_pkg

// file: test/tb_top.sv
// self-checking bench for the sdram timing and ecc register bank
`timescale 1ns/1ps
module tb_top import stec_pkg::*;;
	logic CLOCK = 1'b0;
	logic SRST = 1'b1;
	logic CE = 1'b1;
	logic [ADDR_W-1:0] ADDR = '0;
	logic [31:0] WDATA = '0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [31:0] RDATA;
	stec_event_type EVT = '0;
	stec_timing_type TIMING;
	stec_ecc_cfg_type ECC_CFG;
	logic IRQ;
	int fail_count = 0;
	int samples_checked = 0;
	// clean register map, addresses worked out by hand from the index table
	localparam logic [11:0] A_ROW = 12'h48C, A_TURN = 12'h490, A_REF = 12'h494, A_LAT = 12'h498;
	localparam logic [11:0] A_CTRL = 12'h4C0, A_STAT = 12'h4C4, A_EADDR = 12'h4C8, A_HOLE = 12'h4CC;

	always #4 CLOCK = ~CLOCK;

	stec_csr stec_csr_inst (.CLOCK(CLOCK), .SRST(SRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .EVT(EVT), .TIMING(TIMING), .ECC_CFG(ECC_CFG), .IRQ(IRQ));

	//////////////////////////////////////////////////////////////////////////////
	// shared bus and compare tasks
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// write lasts one cycle; the trailing 1 ns delay keeps strobes from being assigned twice in one step
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		#1;
	endtask : wr

	// read data stands only in the cycle after the strobe, so it is sampled just after that edge
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		check(RDATA, exp);
	endtask : rd_chk

	// one event pulse per cycle for n cycles; flags show just after the last taking edge
	task automatic evt(input logic s, input logic d, input logic l, input logic [31:0] a, input int n);
		@(posedge CLOCK);
		EVT <= stec_event_type'({s, d, l, a});
		repeat (n) @(posedge CLOCK);
		EVT <= '0;
		#1;
	endtask : evt

	//////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		check(TIMING, {32'h140F_4646, 32'h0000_1444, 32'h0034_0618, 32'h0008_6506});
		check(ECC_CFG, 4'h8);
		check(IRQ, 1'b0);
		rd_chk(A_CTRL, 32'h0000_0011);
		rd_chk(A_STAT, 32'h0);
		rd_chk(A_EADDR, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_timing;
		wr(A_ROW, 32'h2813_8B52);
		rd_chk(A_ROW, 32'h2813_8B52);
		wr(A_TURN, 32'hFFFF_2082);
		rd_chk(A_TURN, 32'h0000_2082);
		wr(A_REF, 32'hFF58_1860);
		rd_chk(A_REF, 32'h0058_1860);
		wr(A_LAT, 32'hFFF4_8B27);
		rd_chk(A_LAT, 32'h0004_8B27);
		check(TIMING, {32'h2813_8B52, 32'h0000_2082, 32'h0058_1860, 32'h0004_8B27});
		rd_chk(A_HOLE, 32'h0);
		$display("test timing done");
	endtask : t_timing

	task automatic t_ecc_cfg;
		wr(A_CTRL, 32'h0000_0004);
		check(ECC_CFG, 4'b0001);
		wr(A_CTRL, 32'h0000_000E);
		check(ECC_CFG, 4'b0111);
		rd_chk(A_CTRL, 32'h0000_000E);
		wr(A_CTRL, 32'h0000_000B);
		check(ECC_CFG, 4'b1111);
		wr(A_CTRL, 32'h0000_0011);
		check(ECC_CFG, 4'b1000);
		$display("test ecc steering done");
	endtask : t_ecc_cfg

	task automatic t_events;
		evt(1'b1, 1'b0, 1'b0, 32'h0000_1240, 1);
		check(IRQ, 1'b1);
		rd_chk(A_STAT, 32'h0000_0101);
		evt(1'b0, 1'b1, 1'b0, 32'h0000_3380, 1);
		evt(1'b0, 1'b0, 1'b1, 32'h0000_5550, 1);
		rd_chk(A_STAT, 32'h0101_0107);
		rd_chk(A_EADDR, 32'h0000_3380);
		wr(A_STAT, 32'hFFFF_FFFF);
		rd_chk(A_STAT, 32'h0101_0107);
		wr(A_EADDR, 32'hFFFF_FFFF);
		rd_chk(A_EADDR, 32'h0000_3380);
		wr(A_CTRL, 32'h0000_0091);
		check(IRQ, 1'b0);
		rd_chk(A_STAT, 32'h0);
		rd_chk(A_EADDR, 32'h0);
		rd_chk(A_CTRL, 32'h0000_0011);
		$display("test events done");
	endtask : t_events

	task automatic t_masks;
		wr(A_CTRL, 32'h0000_0171);
		evt(1'b1, 1'b1, 1'b1, 32'h0000_0040, 1);
		check(IRQ, 1'b0);
		rd_chk(A_STAT, 32'h0101_0107);
		wr(A_CTRL, 32'h0000_0131);
		check(IRQ, 1'b1);
		wr(A_CTRL, 32'h0000_0121);
		check(IRQ, 1'b0);
		wr(A_CTRL, 32'h0000_0031);
		check(IRQ, 1'b1);
		wr(A_CTRL, 32'h0000_0091);
		check(IRQ, 1'b0);
		$display("test masks done");
	endtask : t_masks

	// clock enable low freezes the bank, so strobes and events in that time are lost
	task automatic t_freeze;
		@(posedge CLOCK);
		CE <= 1'b0;
		wr(A_ROW, 32'h0A0B_0C0D);
		evt(1'b1, 1'b0, 1'b0, 32'h0000_0100, 1);
		check(TIMING.row, 32'h2813_8B52);
		check(IRQ, 1'b0);
		@(posedge CLOCK);
		CE <= 1'b1;
		rd_chk(A_STAT, 32'h0);
		rd_chk(A_ROW, 32'h2813_8B52);
		$display("test freeze done");
	endtask : t_freeze

	// a long burst of back-to-back single and lost-fix errors drives both tallies to the top, where they hold
	task automatic t_saturate;
		evt(1'b1, 1'b0, 1'b1, 32'h0000_0080, 260);
		rd_chk(A_STAT, 32'hFF00_FF05);
		@(posedge CLOCK);
		SRST <= 1'b1;
		@(posedge CLOCK);
		SRST <= 1'b0;
		#1;
		check(IRQ, 1'b0);
		rd_chk(A_STAT, 32'h0);
		$display("test saturation done");
	endtask : t_saturate

	//////////////////////////////////////////////////////////////////////////////
	// closing and main sequence
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (10) @(posedge CLOCK);
		SRST <= 1'b0;
		#1;
		t_reset();
		t_timing();
		t_ecc_cfg();
		t_events();
		t_masks();
		t_freeze();
		t_saturate();
		tally_and_finish();
	end

	// the run needs under a thousand cycles; five thousand means a hang
	initial begin
		repeat (5000) @(posedge CLOCK);
		fail_count++;
		tally_and_finish();
	end
endmodule : tb_top
